/* rtl/disk_dma_params.svh */
`ifndef DISK_DMA_PARAMS_SVH
`define DISK_DMA_PARAMS_SVH

// register indices, byte address is four times the index
`define IDX_DATA_EARLY 10'h008
`define IDX_GLOBAL_DMA_CONTROL_RD 10'h002
`define IDX_BYTE_STAT 10'h01A
`define IDX_PTR_HIGH 10'h020
`define IDX_PTR_LOW 10'h022
`define IDX_LEN_CTRL 10'h024
`define IDX_DATA_WRITE 10'h026
`define IDX_SYNC_PAT 10'h07E
`define IDX_GLOBAL_DMA_CONTROL_WR 10'h096
`define IDX_IRQ_STAT 10'h100
`define IDX_IRQ_MASK 10'h101

// global dma control fields
`define DC_SETCLR 15
`define DC_BUSY 14
`define DC_ZERO 13
`define DC_BLIT_OVER_CPU_PRIORITY 10
`define DC_MASTER 9
`define DC_BLIT 6
`define DC_DISK 4
`define DC_WBITS 11

// byte status fields
`define BS_READY 15
`define BS_FLOPPY_TRANSFER_ACTIVE 14
`define BS_WRITE 13
`define BS_EQUAL 12

// length register fields
`define LEN_EN 15
`define LEN_DIR 14
`define LEN_CNT_W 14

// interrupt status bits, same layout as the request register
`define IRQ_SYNC 12
`define IRQ_BLOCK 1
`define IRQ_IMPL 16'h1002

// pointer and stream constants
`define PTR_HI_W 3
`define PTR_LO_W 15
`define PTR_STEP 18'h00002
`define BIT_LAST 4'hF
`define BYTE_LAST 3'h7
`define CNT_ONE 14'h0001
`define CNT_ZERO 14'h0000
`define RESET_16 16'h0000

`endif

/* rtl/disk_dma_pkg.sv */
package disk_dma_pkg;

    // memory side sequencer states
    typedef enum logic [1:0] {
        DMA_IDLE,
        DMA_TO_MEM,
        DMA_FROM_MEM
    } dma_state_t;

endpackage : disk_dma_pkg

/* rtl/disk_dma.sv */
`timescale 1ns/1ps
`include "disk_dma_params.svh"

module disk_dma (
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // blitter status and cpu bus request
    input wire logic blit_engine_active_i,
    input wire logic blit_result_all_zero_i,
    input wire logic cpu_bus_request_i,
    output logic cpu_bus_request_out_n_o,
    // per channel run enables, bit order as control bits 08..00
    output logic [8:0] channel_run_o,
    // disk serial stream pins
    input wire logic disk_bit_clk_i,
    input wire logic disk_rd_bit_i,
    output logic disk_wr_bit_o,
    output logic disk_write_mode_o,
    // memory dma port
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [17:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    // interrupt
    output logic irq_o
);

    // register state
    logic [`DC_WBITS-1:0] dma_ctrl;
    logic len_en;
    logic len_dir;
    logic [`LEN_CNT_W-1:0] len_cnt;
    logic [17:0] disk_ptr;
    logic [15:0] sync_pat;
    logic [7:0] byte_buf;
    logic byte_rdy;
    logic [15:0] rx_word;
    logic [15:0] tx_buf;
    logic tx_full;
    logic [15:0] irq_stat;
    logic [15:0] irq_mask;
    logic [31:0] rd_data;
    logic rd_loaded;

    // stream state
    logic clk_s1, clk_s2, clk_s3;
    logic bit_s1, bit_s2;
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [3:0] bit_cnt;
    logic match_prev;
    logic word_pend;
    disk_dma_pkg::dma_state_t state;
    disk_dma_pkg::dma_state_t next_state;

    // bus decode
    wire [9:0] idx = paddr_i[11:2];
    wire acc_done = ce_i & psel_i & penable_i & rd_loaded;
    wire wr_done = acc_done & pwrite_i;
    wire rd_done = acc_done & ~pwrite_i;
    wire hit_early = idx == `IDX_DATA_EARLY;
    wire hit_dcrd = idx == `IDX_GLOBAL_DMA_CONTROL_RD;
    wire hit_byte = idx == `IDX_BYTE_STAT;
    wire hit_pth = idx == `IDX_PTR_HIGH;
    wire hit_ptl = idx == `IDX_PTR_LOW;
    wire hit_len = idx == `IDX_LEN_CTRL;
    wire hit_dat = idx == `IDX_DATA_WRITE;
    wire hit_sync = idx == `IDX_SYNC_PAT;
    wire hit_dcwr = idx == `IDX_GLOBAL_DMA_CONTROL_WR;
    wire hit_ist = idx == `IDX_IRQ_STAT;
    wire hit_imk = idx == `IDX_IRQ_MASK;
    wire hit_rd = hit_early | hit_dcrd | hit_byte | hit_ist | hit_imk;
    wire hit_wr = hit_pth | hit_ptl | hit_len | hit_dat | hit_sync |
                  hit_dcwr | hit_imk;
    wire hit_any = pwrite_i ? hit_wr : hit_rd;

    // enables
    wire master_dma_enable = dma_ctrl[`DC_MASTER];
    wire blit_over_cpu_priority = dma_ctrl[`DC_BLIT_OVER_CPU_PRIORITY];
    wire floppy_transfer_active = len_en & master_dma_enable;
    // disk moves only with master and own enable
    wire dma_run = floppy_transfer_active & dma_ctrl[`DC_DISK];
    wire cnt_zero = len_cnt == `CNT_ZERO;
    wire sync_pattern_match = rx_shift == sync_pat;

    // stream events from the synchronised bit clock
    wire bit_edge = ce_i & clk_s2 & ~clk_s3;
    wire [15:0] next_rx_shift = {rx_shift[14:0], bit_s2};
    wire word_edge = bit_edge & (bit_cnt == `BIT_LAST);
    wire byte_edge = bit_edge & (bit_cnt[2:0] == `BYTE_LAST) & ~len_dir;
    wire sync_rise = ce_i & sync_pattern_match & ~match_prev;

    // dma sequencer handshakes
    wire mem_done = ce_i & mem_ack_i & (state != disk_dma_pkg::DMA_IDLE);
    wire tx_load = word_edge & len_dir;
    wire blk_done = mem_done & (len_cnt == `CNT_ONE);

    // set or clear by bit 15, one bit per writable bit
    logic [`DC_WBITS-1:0] next_dma_ctrl;
    genvar gi;
    generate
        for (gi = 0; gi < `DC_WBITS; gi = gi + 1) begin : g_dc
            assign next_dma_ctrl[gi] = (wr_done & hit_dcwr & pwdata_i[gi]) ?
                pwdata_i[`DC_SETCLR] : dma_ctrl[gi];
            if (gi < `DC_MASTER) begin : g_run
                // each channel gated by its own bit
                // audio channels gated the same way
                assign channel_run_o[gi] = dma_ctrl[gi] & master_dma_enable;
            end
        end
    endgenerate

    // blitter priority holds off the cpu request
    wire blit_hogs = blit_over_cpu_priority & dma_ctrl[`DC_BLIT] &
                     master_dma_enable & blit_engine_active_i;
    assign cpu_bus_request_out_n_o = ~(cpu_bus_request_i & ~blit_hogs);

    // read data views
    logic [15:0] global_dma_control_view;
    logic [15:0] byte_view;
    always_comb begin
        global_dma_control_view = `RESET_16;
        global_dma_control_view[`DC_WBITS-1:0] = dma_ctrl;
        global_dma_control_view[`DC_BUSY] = blit_engine_active_i;
        global_dma_control_view[`DC_ZERO] = blit_result_all_zero_i;
        byte_view = {8'h00, byte_buf};
        byte_view[`BS_READY] = byte_rdy;
        byte_view[`BS_FLOPPY_TRANSFER_ACTIVE] = floppy_transfer_active;
        byte_view[`BS_WRITE] = len_dir;
        byte_view[`BS_EQUAL] = sync_pattern_match;
    end

    wire [15:0] rd_mux = hit_early ? rx_word :
                         hit_dcrd ? global_dma_control_view :
                         hit_byte ? byte_view :
                         hit_ist ? irq_stat :
                         hit_imk ? irq_mask : `RESET_16;

    // apb answer, data captured in the setup cycle
    assign pready_o = ce_i & rd_loaded;
    assign pslverr_o = pready_o & ~hit_any;
    assign prdata_o = rd_data;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rd_loaded <= 1'b0;
            rd_data <= 32'h00000000;
        end else if (ce_i) begin
            rd_loaded <= psel_i & ~acc_done;
            if (psel_i & ~rd_loaded) begin
                rd_data <= {16'h0000, rd_mux};
            end
        end
    end

    // global control register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dma_ctrl <= '0;
        end else if (ce_i) begin
            dma_ctrl <= next_dma_ctrl;
        end
    end

    // length register fields and down counter
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            len_en <= 1'b0;
            len_dir <= 1'b0;
            len_cnt <= `CNT_ZERO;
        end else if (ce_i) begin
            if (wr_done & hit_len) begin
                len_en <= pwdata_i[`LEN_EN];
                len_dir <= pwdata_i[`LEN_DIR];
                len_cnt <= pwdata_i[`LEN_CNT_W-1:0];
            end else if (mem_done) begin
                len_cnt <= len_cnt - `CNT_ONE;
            end
        end
    end

    // pointer halves and post increment per word
    // pointer is taken as loaded, no check against enable order
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            disk_ptr <= '0;
        end else if (ce_i) begin
            if (wr_done & hit_pth) begin
                disk_ptr[17:`PTR_LO_W] <= pwdata_i[`PTR_HI_W-1:0];
            end else if (wr_done & hit_ptl) begin
                disk_ptr[`PTR_LO_W-1:0] <= pwdata_i[`PTR_LO_W:1] <<< 1;
            end else if (mem_done) begin
                disk_ptr <= disk_ptr + `PTR_STEP;
            end
        end
    end

    // sync pattern and interrupt mask
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync_pat <= `RESET_16;
            irq_mask <= `RESET_16;
        end else if (ce_i) begin
            if (wr_done & hit_sync) begin
                sync_pat <= pwdata_i[15:0];
            end
            if (wr_done & hit_imk) begin
                irq_mask <= pwdata_i[15:0] & `IRQ_IMPL;
            end
        end
    end

    // pin synchronisers, first stage read only by the second
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            bit_s1 <= 1'b0;
            bit_s2 <= 1'b0;
        end else if (ce_i) begin
            clk_s1 <= disk_bit_clk_i;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            bit_s1 <= disk_rd_bit_i;
            bit_s2 <= bit_s1;
        end
    end

    // receive shifter, bit counter realigned on a sync match
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rx_shift <= `RESET_16;
            bit_cnt <= 4'h0;
            match_prev <= 1'b1; // reset pattern equals reset shifter
            rx_word <= `RESET_16;
        end else if (ce_i) begin
            match_prev <= sync_pattern_match;
            if (bit_edge) begin
                rx_shift <= next_rx_shift;
                bit_cnt <= bit_cnt + 4'h1;
            end else if (sync_rise & ~len_dir) begin
                bit_cnt <= 4'h0;
            end
            if (word_edge & ~len_dir) begin
                rx_word <= next_rx_shift;
            end
        end
    end

    // byte buffer loaded per received byte
    // status read clears ready, a new byte wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            byte_buf <= 8'h00;
            byte_rdy <= 1'b0;
        end else if (ce_i) begin
            if (byte_edge) begin
                byte_buf <= next_rx_shift[7:0];
                byte_rdy <= 1'b1;
            end else if (rd_done & hit_byte) begin
                byte_rdy <= 1'b0;
            end
        end
    end

    // received word waiting for a memory write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            word_pend <= 1'b0;
        end else if (ce_i) begin
            if (word_edge & ~len_dir & dma_run & ~cnt_zero) begin
                word_pend <= 1'b1;
            end else if (mem_done & ~mem_we_o) begin
                word_pend <= word_pend;
            end else if (mem_done) begin
                word_pend <= 1'b0;
            end else if (~dma_run) begin
                word_pend <= 1'b0;
            end
        end
    end

    // transmit buffer, filled by dma or by a direct write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tx_buf <= `RESET_16;
            tx_full <= 1'b0;
        end else if (ce_i) begin
            if (mem_done & ~mem_we_o) begin
                tx_buf <= mem_rdata_i;
                tx_full <= 1'b1;
            end else if (wr_done & hit_dat) begin
                tx_buf <= pwdata_i[15:0];
                tx_full <= 1'b1;
            end else if (tx_load) begin
                tx_full <= 1'b0;
            end
        end
    end

    // transmit shifter, msb first, zero fill when starved
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tx_shift <= `RESET_16;
            disk_wr_bit_o <= 1'b0;
        end else if (ce_i) begin
            if (bit_edge & len_dir) begin
                disk_wr_bit_o <= tx_shift[15];
                tx_shift <= tx_load ? (tx_full ? tx_buf : `RESET_16) :
                            {tx_shift[14:0], 1'b0};
            end
        end
    end

    // memory sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            disk_dma_pkg::DMA_IDLE: begin
                if (word_pend & dma_run & ~len_dir & ~cnt_zero) begin
                    next_state = disk_dma_pkg::DMA_TO_MEM;
                end else if (dma_run & len_dir & ~tx_full & ~cnt_zero) begin
                    next_state = disk_dma_pkg::DMA_FROM_MEM;
                end
            end
            disk_dma_pkg::DMA_TO_MEM,
            disk_dma_pkg::DMA_FROM_MEM: begin
                if (mem_ack_i) begin
                    next_state = disk_dma_pkg::DMA_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= disk_dma_pkg::DMA_IDLE;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // memory port, request held until acknowledged
    assign mem_req_o = state != disk_dma_pkg::DMA_IDLE;
    assign mem_we_o = state == disk_dma_pkg::DMA_TO_MEM;
    assign mem_addr_o = disk_ptr;
    assign mem_wdata_o = rx_word;
    assign disk_write_mode_o = len_dir & dma_run;

    // sync match sets its request bit
    // last word moved sets block done
    wire [15:0] irq_set = ({15'h0000, sync_rise} << `IRQ_SYNC) |
                          ({15'h0000, blk_done} << `IRQ_BLOCK);
    wire irq_clr = rd_done & hit_ist;

    // sticky status, read clears, new event wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_stat <= `RESET_16;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_stat <= irq_set | (irq_clr ? `RESET_16 : irq_stat);
            irq_o <= |((irq_set | (irq_clr ? `RESET_16 : irq_stat)) &
                       irq_mask);
        end
    end

endmodule : disk_dma

/* verification/disk_dma_assertions.sv */
`timescale 1ns/1ps
module disk_dma_assertions (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // blitter and cpu
    input wire logic blit_engine_active_i,
    input wire logic blit_result_all_zero_i,
    input wire logic cpu_bus_request_i,
    input wire logic cpu_bus_request_out_n_o,
    input wire logic [8:0] channel_run_o,
    // memory port
    input wire logic mem_req_o,
    input wire logic mem_ack_i,
    input wire logic [17:0] mem_addr_o
);
    logic [10:0] ctl;
    logic len_en;
    logic len_dir;
    wire wr_ok = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
    wire [9:0] idx = paddr_i[11:2];

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // shadow of control and length writes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctl <= 11'h000;
            len_en <= 1'b0;
            len_dir <= 1'b0;
        end else if (wr_ok && idx == 10'h096) begin
            ctl <= pwdata_i[15] ? ctl | pwdata_i[10:0] : ctl & ~pwdata_i[10:0];
        end else if (wr_ok && idx == 10'h024) begin
            len_en <= pwdata_i[15];
            len_dir <= pwdata_i[14];
        end
    end

    // completed read of one index
    sequence s_rd(i);
        psel_i && penable_i && pready_o && !pwrite_i && idx == i;
    endsequence

    a_run_gated: assert property (
        channel_run_o == (ctl[8:0] & {9{ctl[9]}}))
        else $error("channel run differs from control");
    a_cpu_hold: assert property (
        cpu_bus_request_out_n_o == !(cpu_bus_request_i &&
        !(ctl[10] && ctl[6] && ctl[9] && blit_engine_active_i)))
        else $error("cpu bus request wrong");
    a_zero_wait: assert property (
        psel_i && penable_i && ce_i |-> pready_o)
        else $error("apb wait state seen");
    a_bad_index: assert property (
        s_rd(10'h096) |-> pslverr_o)
        else $error("read of write-only index not refused");
    a_stat_unused: assert property (
        s_rd(10'h01A) |-> prdata_o[11:8] == 4'h0)
        else $error("status unused bits set");
    a_stat_mirror: assert property (
        s_rd(10'h01A) |-> prdata_o[14] == (len_en && ctl[9])
        && prdata_o[13] == len_dir)
        else $error("status mirror bits wrong");
    a_ctl_read: assert property (
        s_rd(10'h002) |-> prdata_o[10:0] == ctl
        && prdata_o[14] == $past(blit_engine_active_i)
        && prdata_o[13] == $past(blit_result_all_zero_i))
        else $error("control read wrong");
    a_mem_hold: assert property (
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("memory request not held");
    a_mem_step: assert property (
        mem_req_o && mem_ack_i && ce_i |=> !mem_req_o
        && mem_addr_o == $past(mem_addr_o) + 18'h00002)
        else $error("pointer step wrong");
endmodule : disk_dma_assertions

bind disk_dma disk_dma_assertions i_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .blit_engine_active_i(blit_engine_active_i),
    .blit_result_all_zero_i(blit_result_all_zero_i),
    .cpu_bus_request_i(cpu_bus_request_i),
    .cpu_bus_request_out_n_o(cpu_bus_request_out_n_o),
    .channel_run_o(channel_run_o), .mem_req_o(mem_req_o),
    .mem_ack_i(mem_ack_i), .mem_addr_o(mem_addr_o)
);

/* verification/disk_drive_model.sv */
`timescale 1ns/1ps
module disk_drive_model (
    // pacing clock
    input wire logic clk_sys_i,
    // serial stream
    output logic disk_bit_clk_o,
    output logic disk_rd_bit_o,
    // write stream back from the block
    input wire logic disk_wr_bit_i,
    output logic [15:0] wr_word_o
);
    // capture the write stream on each falling bit clock
    always @(negedge disk_bit_clk_o) begin
        wr_word_o <= {wr_word_o[14:0], disk_wr_bit_i};
    end

    // idle levels
    initial begin
        disk_bit_clk_o = 1'b0;
        disk_rd_bit_o = 1'b0;
    end

    // one word msb first, bit clock still between frames
    task automatic send_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_sys_i);
            disk_rd_bit_o <= w[i];
            repeat (3) @(posedge clk_sys_i);
            disk_bit_clk_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            disk_bit_clk_o <= 1'b0;
        end
        @(posedge clk_sys_i);
        disk_rd_bit_o <= ~w[0]; // released line shows no stale bit
    endtask : send_word
endmodule : disk_drive_model

/* verification/tb_disk_dma.sv */
`timescale 1ns/1ps
module tb_disk_dma;
    logic clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic busy, zero, cpu_req, cpu_n, wr_bit, wmode, irq, err;
    logic mem_req, mem_we, mem_ack, bclk, rbit;
    logic [8:0] run;
    logic [17:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata, wr_word;
    logic [15:0] words [3] = '{16'h1357, 16'h2468, 16'hC3A5};
    int bad_count, n_compared, mem_n;

    disk_dma i_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .blit_engine_active_i(busy),
        .blit_result_all_zero_i(zero), .cpu_bus_request_i(cpu_req),
        .cpu_bus_request_out_n_o(cpu_n), .channel_run_o(run),
        .disk_bit_clk_i(bclk), .disk_rd_bit_i(rbit), .disk_wr_bit_o(wr_bit),
        .disk_write_mode_o(wmode), .mem_req_o(mem_req), .mem_we_o(mem_we),
        .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack),
        .mem_rdata_i(mem_rdata), .irq_o(irq)
    );

    disk_drive_model i_drive (
        .clk_sys_i(clk_sys_i), .disk_bit_clk_o(bclk), .disk_rd_bit_o(rbit),
        .disk_wr_bit_i(wr_bit), .wr_word_o(wr_word)
    );

    // system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer, setup then access until ready
    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [15:0] wd);
        int n;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge clk_sys_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            bad_count++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [9:0] idx, input logic [31:0] m,
                        input logic [31:0] exp);
        apb(1'b0, idx, 16'h0000);
        check("read", rd & m, exp);
    endtask : rchk

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // memory responder, one ack per request
    always @(posedge clk_sys_i) begin
        mem_ack <= mem_req && !mem_ack;
        if (mem_req && !mem_ack) begin
            mem_rdata <= words[mem_n];
            check("addr", {14'h0, mem_addr}, 32'h09234 + 2 * mem_n);
            if (mem_n < 2) begin
                check("data", {16'h0, mem_wdata}, {16'h0, words[mem_n]});
            end
            check("we", {31'h0, mem_we}, {31'h0, mem_n < 2});
            mem_n++;
        end
    end

    // watchdog
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end

    // main sequence
    initial begin
        rst_i = 1'b1;
        {psel, penable, pwrite, busy, zero} = 5'h00;
        cpu_req = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        mem_n = 0;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 10'h096, 16'h8200 | (16'h0001 << i));
            @(negedge clk_sys_i);
            check("run", {23'h0, run}, 32'h1 << i);
            apb(1'b1, 10'h096, 16'h0001 << i);
        end
        apb(1'b1, 10'h096, 16'hE650);
        @(posedge clk_sys_i);
        busy <= 1'b1;
        zero <= 1'b1;
        @(negedge clk_sys_i);
        check("cpu_n", {31'h0, cpu_n}, 32'h1);
        rchk(10'h002, 32'h67FF, 32'h6650);
        @(posedge clk_sys_i);
        busy <= 1'b0;
        zero <= 1'b0;
        @(negedge clk_sys_i);
        check("cpu_n", {31'h0, cpu_n}, 32'h0);
        rchk(10'h002, 32'h67FF, 32'h0650);
        apb(1'b1, 10'h096, 16'h0200);
        @(negedge clk_sys_i);
        check("run", {23'h0, run}, 32'h0);
        rchk(10'h002, 32'h07FF, 32'h0450);
        apb(1'b1, 10'h096, 16'h8200);
        apb(1'b0, 10'h096, 16'h0000);
        check("err", {31'h0, err}, 32'h1);
        apb(1'b1, 10'h101, 16'h1002);
        apb(1'b1, 10'h024, 16'h4000);
        rchk(10'h01A, 32'h6000, 32'h2000);
        apb(1'b1, 10'h024, 16'h0000);
        apb(1'b1, 10'h07E, 16'h4489);
        i_drive.send_word(16'h4489);
        rchk(10'h01A, 32'h1000, 32'h1000);
        check("irq", {31'h0, irq}, 32'h1);
        rchk(10'h100, 32'h1000, 32'h1000);
        repeat (2) @(negedge clk_sys_i);
        check("irq", {31'h0, irq}, 32'h0);
        i_drive.send_word(16'hA55A);
        rchk(10'h01A, 32'h90FF, 32'h005A | 32'h8000);
        rchk(10'h01A, 32'h8000, 32'h0000);
        apb(1'b1, 10'h020, 16'h0001);
        apb(1'b1, 10'h022, 16'h1234);
        apb(1'b1, 10'h024, 16'h8002);
        rchk(10'h01A, 32'h6000, 32'h4000);
        i_drive.send_word(words[0]);
        i_drive.send_word(words[1]);
        for (int n = 0; n < 200 && mem_n < 2; n++) begin
            @(posedge clk_sys_i);
        end
        repeat (4) @(posedge clk_sys_i);
        check("words", mem_n, 32'h2);
        check("irq", {31'h0, irq}, 32'h1);
        rchk(10'h100, 32'h1002, 32'h0002);
        apb(1'b1, 10'h096, 16'h0200);
        rchk(10'h01A, 32'h4000, 32'h0000);
        rchk(10'h008, 32'hFFFF, 32'h2468);
        // memory to disk: one word fetched, then shifted out msb first
        apb(1'b1, 10'h096, 16'h8200);
        apb(1'b1, 10'h024, 16'hC001);
        @(negedge clk_sys_i);
        check("wmode", {31'h0, wmode}, 32'h1);
        rchk(10'h01A, 32'h6000, 32'h6000);
        i_drive.send_word(16'h0000);
        i_drive.send_word(16'h0000);
        check("tx", {16'h0, wr_word}, {16'h0, words[2]});
        check("words", mem_n, 32'h3);
        check("irq", {31'h0, irq}, 32'h1);
        rchk(10'h100, 32'h1002, 32'h0002);
        apb(1'b1, 10'h096, 16'h0200);
        @(negedge clk_sys_i);
        check("wmode", {31'h0, wmode}, 32'h0);
        complete_run();
    end
endmodule : tb_disk_dma
